/* File: hdl/iord_decoder.sv */
// iord_decoder.sv: io address decoder for core and added peripheral registers
// assumes the core drives one io cycle per valid pulse, synchronous to clock
//
// Functional notes
// RULE_01 - core control block decodes at 00h-3Fh after reset
// RULE_02 - core block may be moved to 040h-07Fh or 080h-0BFh
// RULE_03 - core block base moves only in 64-address steps via core io control
// RULE_04 - software must never place core block at 0C0h, overlaps E0h group
// RULE_05 - fixed 16 addresses E0h-EFh hold added registers; EEh, EFh reserved
// RULE_06 - E0h first port direction, E1h first port data
// RULE_07 - E2h second port direction, E3h second port data
// RULE_08 - E4h to E7h select timer channel 0 to 3 control
// RULE_09 - E8h serial control, E9h serial data
// RULE_10 - EAh RAM upper bound, EBh RAM lower bound
// RULE_11 - ECh ROM boundary register
// RULE_12 - EDh system configuration register
// RULE_13 - software clears operation mode bit D7 at initialisation
// RULE_14 - software clears operation mode bit D5 at initialisation
// RULE_15 - all eight address lines decoded, no aliases
// RULE_16 - each added register is eight bits wide
// RULE_17 - at most one select per cycle, none for reserved or unmapped
`timescale 1ns/1ns
module iord_decoder
  import iord_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // io cycle from the core
  input wire iord_req_t req,
  // core block relocation, written by the core io control register
  input wire logic core_reloc_wr,
  input wire logic [7:0] core_reloc_data,
  // selects
  output iord_sel_t sel,
  output logic core_sel,
  output logic [5:0] core_offset,
  output logic [1:0] core_base,
  // read answer
  output logic [7:0] rdata,
  output logic rdata_valid,
  // register contents for the peripherals
  output logic [7:0] port1_direction,
  output logic [7:0] port1_data,
  output logic [7:0] port2_direction,
  output logic [7:0] port2_data,
  output logic [7:0] system_config
);
`include "iord_defs.svh"

  // ----------------------------------------
  // decode function
  // ----------------------------------------
  function automatic iord_sel_t decode(input logic [7:0] a, input logic [1:0] base);
    iord_sel_t s;
    s = iord_sel_none;
    if (a[7:6] == base && base != 2'h3)                 // RULE_01 RULE_02
      s = iord_sel_core;
    else if (a == `IORD_ADDR_P1_DIR)                    // RULE_06 RULE_15
      s = iord_sel_p1_dir;
    else if (a == `IORD_ADDR_P1_DATA)                   // RULE_06
      s = iord_sel_p1_data;
    else if (a == `IORD_ADDR_P2_DIR)                    // RULE_07
      s = iord_sel_p2_dir;
    else if (a == `IORD_ADDR_P2_DATA)                   // RULE_07
      s = iord_sel_p2_data;
    else if (a == `IORD_ADDR_TMR0)                      // RULE_08
      s = iord_sel_tmr0;
    else if (a == `IORD_ADDR_TMR1)                      // RULE_08
      s = iord_sel_tmr1;
    else if (a == `IORD_ADDR_TMR2)                      // RULE_08
      s = iord_sel_tmr2;
    else if (a == `IORD_ADDR_TMR3)                      // RULE_08
      s = iord_sel_tmr3;
    else if (a == `IORD_ADDR_SER_CTRL)                  // RULE_09
      s = iord_sel_ser_ctrl;
    else if (a == `IORD_ADDR_SER_DATA)                  // RULE_09
      s = iord_sel_ser_data;
    else if (a == `IORD_ADDR_RAM_UB)                    // RULE_10
      s = iord_sel_ram_ub;
    else if (a == `IORD_ADDR_RAM_LB)                    // RULE_10
      s = iord_sel_ram_lb;
    else if (a == `IORD_ADDR_ROM_UB)                    // RULE_11
      s = iord_sel_rom_ub;
    else if (a == `IORD_ADDR_SYS_CFG)                   // RULE_12
      s = iord_sel_sys_cfg;
    else if (a == `IORD_ADDR_RSVD_EE || a == `IORD_ADDR_RSVD_EF) // RULE_05
      s = iord_sel_reserved;
    return s;
  endfunction : decode

  // ----------------------------------------
  // core block base
  // ----------------------------------------
  // base 3 would collide with the added group; it is stored but never decoded
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      core_base <= `IORD_CORE_BASE_RST;                 // RULE_01
    else if (core_reloc_wr)
      core_base <= core_reloc_data[`IORD_RELOC_MSB:`IORD_RELOC_LSB]; // RULE_03 RULE_04
  end

  // ----------------------------------------
  // decode and selects
  // ----------------------------------------
  iord_sel_t cur_sel;
  logic [3:0] reg_index;
  logic peri_hit;

  always_comb
  begin
    cur_sel = req.valid ? decode(req.addr, core_base) : iord_sel_none;
    peri_hit = cur_sel != iord_sel_none && cur_sel != iord_sel_core
               && cur_sel != iord_sel_reserved;          // RULE_17
    reg_index = req.addr[3:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sel <= iord_sel_none;
      core_sel <= 1'b0;
      core_offset <= 6'h00;
    end
    else
    begin
      sel <= cur_sel;                                   // RULE_17
      core_sel <= cur_sel == iord_sel_core;
      core_offset <= req.addr[5:0];
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] mem_rdata;

  iord_regfile #(
    .DEPTH(14),
    .WIDTH(8)                                           // RULE_16
  ) u_regs (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(peri_hit && req.write),
    .index(reg_index),
    .wdata(req.wdata),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // mirror copies for peripheral steering
  // ----------------------------------------
  // one flop group per steered register, so each load stays local to its peripheral
  logic mirror_wr;

  assign mirror_wr = req.valid && req.write;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      port1_direction <= `IORD_REG_RST;
    else if (mirror_wr && cur_sel == iord_sel_p1_dir)   // RULE_06
      port1_direction <= req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      port1_data <= `IORD_REG_RST;
    else if (mirror_wr && cur_sel == iord_sel_p1_data)  // RULE_06
      port1_data <= req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      port2_direction <= `IORD_REG_RST;
    else if (mirror_wr && cur_sel == iord_sel_p2_dir)   // RULE_07
      port2_direction <= req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      port2_data <= `IORD_REG_RST;
    else if (mirror_wr && cur_sel == iord_sel_p2_data)  // RULE_07
      port2_data <= req.wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      system_config <= `IORD_REG_RST;
    else if (mirror_wr && cur_sel == iord_sel_sys_cfg)  // RULE_12
      system_config <= req.wdata;
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  // reserved and unmapped reads give zero and no valid flag
  logic rd_hit;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rd_hit <= 1'b0;
    else
      rd_hit <= peri_hit && !req.write;                 // RULE_17
  end

  always_comb
  begin
    rdata_valid = rd_hit;
    rdata = rd_hit ? mem_rdata : 8'h00;
  end
endmodule : iord_decoder

/* File: hdl/iord_defs.svh */
// iord_defs.svh: offsets, field positions and reset values for the io decoder
// assumes inclusion from the decoder and register file modules only
`ifndef IORD_DEFS_SVH
`define IORD_DEFS_SVH
`define IORD_CORE_SPAN 8'h40
`define IORD_CORE_BASE_RST 2'h0
`define IORD_PERI_BASE 8'he0
`define IORD_PERI_TOP 8'hef
`define IORD_ADDR_P1_DIR 8'he0
`define IORD_ADDR_P1_DATA 8'he1
`define IORD_ADDR_P2_DIR 8'he2
`define IORD_ADDR_P2_DATA 8'he3
`define IORD_ADDR_TMR0 8'he4
`define IORD_ADDR_TMR1 8'he5
`define IORD_ADDR_TMR2 8'he6
`define IORD_ADDR_TMR3 8'he7
`define IORD_ADDR_SER_CTRL 8'he8
`define IORD_ADDR_SER_DATA 8'he9
`define IORD_ADDR_RAM_UB 8'hea
`define IORD_ADDR_RAM_LB 8'heb
`define IORD_ADDR_ROM_UB 8'hec
`define IORD_ADDR_SYS_CFG 8'hed
`define IORD_ADDR_RSVD_EE 8'hee
`define IORD_ADDR_RSVD_EF 8'hef
`define IORD_REG_RST 8'h00
`define IORD_RELOC_LSB 6
`define IORD_RELOC_MSB 7
`endif

/* File: hdl/iord_pkg.sv */
// iord_pkg.sv: types shared by the io register decoder
// assumes iord_defs.svh on the include path
package iord_pkg;
  typedef enum logic [4:0] {
    iord_sel_none,
    iord_sel_core,
    iord_sel_p1_dir,
    iord_sel_p1_data,
    iord_sel_p2_dir,
    iord_sel_p2_data,
    iord_sel_tmr0,
    iord_sel_tmr1,
    iord_sel_tmr2,
    iord_sel_tmr3,
    iord_sel_ser_ctrl,
    iord_sel_ser_data,
    iord_sel_ram_ub,
    iord_sel_ram_lb,
    iord_sel_rom_ub,
    iord_sel_sys_cfg,
    iord_sel_reserved
  } iord_sel_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iord_req_t;
endpackage : iord_pkg

/* File: hdl/iord_regfile.sv */
// iord_regfile.sv: fourteen 8-bit peripheral registers, registered read data
// assumes one write or read per cycle, index already decoded
`timescale 1ns/1ns
module iord_regfile
  import iord_pkg::*;
#(
  parameter int DEPTH = 14,
  parameter int WIDTH = 8
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // access
  input wire logic wr_en,
  input wire logic [3:0] index,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
`include "iord_defs.svh"
  // index is four bits wide, so more than 16 words cannot be reached
  if (DEPTH > 16 || DEPTH < 1 || WIDTH != 8)
  begin : g_bad_param
    $error("iord_regfile: unsupported depth or width");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_word
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          mem[g] <= `IORD_REG_RST;
        else if (wr_en && index == 4'(g))
          mem[g] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata <= `IORD_REG_RST;
    else if (32'(index) < DEPTH)
      rdata <= mem[index];
    else
      rdata <= `IORD_REG_RST;
  end
endmodule : iord_regfile

/* File: verif/io_register_decoder_tb.sv */
// io_register_decoder_tb.sv: self-checking bench for the io decoder
// assumes the core model as the only source of io cycles
`timescale 1ns/1ns
module io_register_decoder_tb
  import iord_pkg::*;
;
  logic clock;
  logic rst_n;
  iord_req_t req;
  logic reloc_wr;
  logic [7:0] reloc_data;
  iord_sel_t sel;
  logic core_sel;
  logic [5:0] core_offset;
  logic [1:0] core_base;
  logic [7:0] rdata;
  logic rdata_valid;
  logic [7:0] p1_data;
  logic [7:0] scfg;
  logic [7:0] p1_dir;
  logic [7:0] p2_dir;
  logic [7:0] p2_data;
  int n_errors = 0;
  int n_checks = 0;
  iord_core_model core (.clock(clock), .req(req), .core_reloc_wr(reloc_wr),
    .core_reloc_data(reloc_data));
  iord_decoder dut (.clock(clock), .rst_n(rst_n), .req(req), .core_reloc_wr(reloc_wr),
    .core_reloc_data(reloc_data), .sel(sel), .core_sel(core_sel),
    .core_offset(core_offset), .core_base(core_base), .rdata(rdata),
    .rdata_valid(rdata_valid), .port1_direction(p1_dir), .port1_data(p1_data),
    .port2_direction(p2_dir), .port2_data(p2_data), .system_config(scfg));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic test_done;
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic t_peri;
    logic [7:0] a;
    for (int i = 0; i < 32; i++)
    begin
      a = 8'he0 + 8'(i % 16);
      core.io(i < 16, a, a ^ 8'h5a);
      if (i % 16 > 13)
        chk(!core_sel && !rdata_valid && rdata === 8'h00, "reserved answered");
      else if (i < 16)
        chk(sel === iord_sel_t'(5'd2 + 5'(i)), "select");
      else
        chk(rdata_valid === 1'b1 && rdata === (a ^ 8'h5a), "read back");
    end
    chk(p1_data === 8'hbb && scfg === 8'hb7, "register outputs");
    chk(p1_dir === 8'hba && p2_dir === 8'hb8 && p2_data === 8'hb9, "port outputs");
  endtask : t_peri
  task automatic t_core;
    logic [7:0] a;
    for (int b = 0; b < 3; b++)
    begin
      core.relocate(2'(b));
      core.init_mode(2'(b));
      chk(core_base === 2'(b) && core_sel === 1'b1, "core base");
      core.io(1'b0, {2'(b), 6'h3f}, 8'h00);
      chk(core_sel === 1'b1 && core_offset === 6'h3f, "core top");
      a = {2'(b + 1), 6'h00};
      core.io(1'b0, a, 8'h00);
      chk(core_sel === 1'b0 && sel === iord_sel_none, "past window");
      core.io(1'b0, 8'h10, 8'h00);
      chk(core_sel === (b == 0), "home window");
    end
    // images of the added group with address bit 4 (Fx) or bits 5 and 4 (Dx) flipped; base 2 leaves them unclaimed
    for (int i = 0; i < 8; i++)
    begin
      a = {(i % 2 == 0) ? 4'hd : 4'hf, 1'b0, 3'(i)};
      core.io(1'b0, a, 8'h00);
      chk(sel === iord_sel_none && rdata_valid === 1'b0, "alias");
    end
  endtask : t_core
  task automatic t_reset;
    core.io(1'b1, 8'he1, 8'h3c);
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(core_base === 2'h0 && p1_data === 8'h00 && scfg === 8'h00, "mid reset");
    core.io(1'b0, 8'h10, 8'h00);
    chk(core_sel === 1'b1 && core_offset === 6'h10, "core home");
    core.io(1'b0, 8'he1, 8'h00);
    chk(rdata_valid === 1'b1 && rdata === 8'h00, "register cleared");
  endtask : t_reset
  initial
  begin
    #800000;
    n_errors++;
    test_done();
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(sel === iord_sel_none && core_base === 2'h0 && p1_data === 8'h00, "reset");
    t_peri();
    t_core();
    t_reset();
    test_done();
  end
endmodule : io_register_decoder_tb

/* File: verif/iord_core_model.sv */
// iord_core_model.sv: processor core issuing io cycles
// assumes calls from the bench; drives at the falling edge
`timescale 1ns/1ns
module iord_core_model
  import iord_pkg::*;
#(
  parameter logic [5:0] OPMODE_OFS = 6'h3e
)
(
  // clock
  input wire logic clock,
  // io cycle and relocation
  output iord_req_t req,
  output logic core_reloc_wr,
  output logic [7:0] core_reloc_data
);
  initial
  begin
    req = '0;
    core_reloc_wr = 1'b0;
    core_reloc_data = 8'h00;
  end
  // released lines show the inverse, so a stale address never decodes
  task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge clock);
    req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
  endtask : io
  task automatic relocate(input logic [1:0] base);
    if (base != 2'h3)
    begin
      @(negedge clock);
      core_reloc_wr <= 1'b1;
      core_reloc_data <= {base, 6'h00};
      @(negedge clock);
      core_reloc_wr <= 1'b0;
      core_reloc_data <= {~base, 6'h3f};
    end
  endtask : relocate
  task automatic init_mode(input logic [1:0] base);
    io(1'b1, {base, OPMODE_OFS}, 8'h00);
  endtask : init_mode
endmodule : iord_core_model

/* File: verif/iord_decoder_asserts.sv */
// iord_decoder_asserts.sv: port timing checks for the io decoder
// assumes a bind onto iord_decoder, one clock domain
`timescale 1ns/1ns
module iord_decoder_asserts
  import iord_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // io cycle and relocation
  input wire iord_req_t req,
  input wire logic core_reloc_wr,
  input wire logic [7:0] core_reloc_data,
  // answers
  input wire iord_sel_t sel,
  input wire logic core_sel,
  input wire logic [5:0] core_offset,
  input wire logic [1:0] core_base,
  input wire logic rdata_valid,
  input wire logic [7:0] port1_data,
  input wire logic [7:0] system_config
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic peri;
  assign peri = req.valid && req.addr[7:4] == 4'he && req.addr[3:0] < 4'he;
  AST_CORE_RST: assert property (req.valid && core_base == 2'h0 && req.addr < 8'h40
    |=> core_sel && core_offset == $past(req.addr[5:0])) else $error("core miss");
  AST_CORE_MOVE: assert property (req.valid && core_base != 2'h3
    && req.addr[7:6] == core_base |=> core_sel) else $error("moved core miss");
  AST_BASE_STEP: assert property (core_reloc_wr
    |=> core_base == $past(core_reloc_data[7:6])) else $error("base not loaded");
  AST_PERI_MAP: assert property (peri
    |=> sel == iord_sel_t'(5'd2 + 5'($past(req.addr[3:0])))) else $error("wrong select");
  AST_RSVD: assert property (req.valid && req.addr[7:1] == 7'h77
    |=> !rdata_valid && !core_sel) else $error("reserved answered");
  AST_NO_ALIAS: assert property (req.valid && req.addr >= 8'hc0 && req.addr[7:4] != 4'he
    |=> sel == iord_sel_none && !core_sel) else $error("alias decoded");
  AST_P1_WR: assert property (req.valid && req.write && req.addr == 8'he1
    |=> port1_data == $past(req.wdata)) else $error("port data not written");
  AST_CFG_WR: assert property (req.valid && req.write && req.addr == 8'hed
    |=> system_config == $past(req.wdata)) else $error("config not written");
  AST_READ: assert property (peri && !req.write |=> rdata_valid)
    else $error("read not answered");
  AST_ONE_SEL: assert property (core_sel |-> sel == iord_sel_core && !rdata_valid)
    else $error("two selects");
  AST_IDLE: assert property (!req.valid
    |=> sel == iord_sel_none && !core_sel && !rdata_valid) else $error("select without cycle");
  cover property (peri && !req.write);
  cover property (core_sel && core_base != 2'h0);
  cover property (core_reloc_wr);
  cover property (req.valid && req.addr == 8'hee);
endmodule : iord_decoder_asserts

bind iord_decoder iord_decoder_asserts u_asserts (.clock(clock), .rst_n(rst_n), .req(req),
  .core_reloc_wr(core_reloc_wr), .core_reloc_data(core_reloc_data), .sel(sel),
  .core_sel(core_sel), .core_offset(core_offset), .core_base(core_base),
  .rdata_valid(rdata_valid), .port1_data(port1_data), .system_config(system_config));
